// [bldm_pkg.sv]
// constants, field layout and state type of the line draw and mix engine
// assumes a plain register port on clk_sys and a pixel memory port answering in one cycle
package bldm_pkg;
    localparam int ADDR_W = 8;
    localparam int PIX_W  = 8;
    localparam int CRD_W  = 16;

    // register offsets
    localparam logic [7:0] OFF_ERR    = 8'h20;
    localparam logic [7:0] OFF_K1     = 8'h24;
    localparam logic [7:0] OFF_K2     = 8'h28;
    localparam logic [7:0] OFF_FGMIX  = 8'h48;
    localparam logic [7:0] OFF_BGMIX  = 8'h4c;
    localparam logic [7:0] OFF_FGCOL  = 8'h58;
    localparam logic [7:0] OFF_BGCOL  = 8'h5c;
    localparam logic [7:0] OFF_DIM1   = 8'h60;
    localparam logic [7:0] OFF_DIM2   = 8'h62;
    localparam logic [7:0] OFF_MSKX   = 8'h6c;
    localparam logic [7:0] OFF_MSKY   = 8'h6e;
    localparam logic [7:0] OFF_SRCX   = 8'h70;
    localparam logic [7:0] OFF_SRCY   = 8'h72;
    localparam logic [7:0] OFF_PATX   = 8'h74;
    localparam logic [7:0] OFF_PATY   = 8'h76;
    localparam logic [7:0] OFF_DSTX   = 8'h78;
    localparam logic [7:0] OFF_DSTY   = 8'h7a;
    localparam logic [7:0] OFF_PIXOP  = 8'h7c;
    localparam logic [7:0] OFF_STATUS = 8'h80;

    // control word field positions
    localparam int OP_BGSRC = 30;
    localparam int OP_FGSRC = 28;
    localparam int OP_STEP  = 24;
    localparam int OP_SMAP  = 20;
    localparam int OP_DMAP  = 16;
    localparam int OP_PMAP  = 12;
    localparam int OP_MASK  = 6;
    localparam int OP_MODE  = 4;
    localparam int OP_NEGX  = 2;
    localparam int OP_NEGY  = 1;
    localparam int OP_SWAP  = 0;

    // field codes
    localparam logic [1:0] SRC_COLOUR  = 2'h0;
    localparam logic [1:0] SRC_MAP     = 2'h2;
    localparam logic [3:0] STEP_LREAD  = 4'h3;
    localparam logic [3:0] STEP_LWRITE = 4'h5;
    localparam logic [3:0] PAT_FIXED   = 4'h8;
    localparam logic [3:0] PAT_FROMSRC = 4'h9;
    localparam logic [1:0] MASK_OFF    = 2'h0;
    localparam logic [1:0] MODE_ALL    = 2'h0;
    localparam logic [1:0] MODE_FIRSTN = 2'h1;
    localparam logic [1:0] MODE_LASTN  = 2'h2;
    localparam logic [1:0] MODE_BOUND  = 2'h3;
    localparam logic [3:0] MAP_MASK_ID = 4'hf;

    // reset values and the unit step
    localparam logic [15:0] RST16 = 16'h0000;
    localparam logic [7:0]  RST8  = 8'h00;
    localparam logic [31:0] RST32 = 32'h0000_0000;
    localparam logic [15:0] ONE16 = 16'h0001;

    // read kinds, one bit each in the pending set
    localparam int NEED_MSK = 0;
    localparam int NEED_PAT = 1;
    localparam int NEED_SRC = 2;
    localparam int NEED_DST = 3;

    // status bits
    localparam int ST_BUSY  = 0;
    localparam int ST_BADOP = 1;
    localparam int ST_PIX   = 8;

    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_RD, S_CAP, S_WR, S_STEP
    } bldm_state_t;
endpackage

// [bldm_mix_unit.sv]
// combinational mix of one source pixel with one destination pixel
// assumes the caller registers the result
`timescale 1ns/1ps
module bldm_mix_unit (
    input  wire logic [7:0]                code,
    input  wire logic [bldm_pkg::PIX_W-1:0] src,
    input  wire logic [bldm_pkg::PIX_W-1:0] dst,
    output logic      [bldm_pkg::PIX_W-1:0] res
);
    import bldm_pkg::*;

    logic [PIX_W:0] sum;
    logic [PIX_W:0] avg;

    // widened sum for saturation and average
    assign sum = {1'b0, src} + {1'b0, dst};
    assign avg = sum >> 1;

    // logical and arithmetic functions
    always_comb
    begin
        case (code)
            8'h00: res = {PIX_W{1'b0}};
            8'h01: res = src & dst;
            8'h02: res = src & ~dst;
            8'h03: res = src;
            8'h04: res = ~src & dst;
            8'h05: res = dst;
            8'h06: res = src ^ dst;
            8'h07: res = src | dst;
            8'h08: res = ~src & ~dst;
            8'h09: res = src ^ ~dst;
            8'h0a: res = ~dst;
            8'h0b: res = src | ~dst;
            8'h0c: res = ~src;
            8'h0d: res = ~src | dst;
            8'h0e: res = ~src | ~dst;
            8'h0f: res = {PIX_W{1'b1}};
            8'h10: res = (src > dst) ? src : dst;
            8'h11: res = (src < dst) ? src : dst;
            8'h12: res = sum[PIX_W] ? {PIX_W{1'b1}} : sum[PIX_W-1:0];
            8'h13: res = (dst > src) ? dst - src : {PIX_W{1'b0}};
            8'h14: res = (src > dst) ? src - dst : {PIX_W{1'b0}};
            8'h15: res = avg[PIX_W-1:0];
            default: res = dst;             // undefined codes leave the pixel
        endcase
    end
endmodule

// [bldm_line_engine.sv]
// register file, line walker and pixel port of the line draw and mix engine
// assumes a pixel memory on clk_sys whose read data stand in the cycle mem_rd_q is high
`timescale 1ns/1ps
module bldm_line_engine (
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    input  wire logic [bldm_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata_q,
    output logic                            busy_q,
    output logic                            mem_rd_q,
    output logic                            mem_wr_q,
    output logic      [3:0]                 mem_map_q,
    output logic      [bldm_pkg::CRD_W-1:0] mem_x_q,
    output logic      [bldm_pkg::CRD_W-1:0] mem_y_q,
    output logic      [bldm_pkg::PIX_W-1:0] mem_wdata_q,
    input  wire logic [bldm_pkg::PIX_W-1:0] mem_rdata
);
    import bldm_pkg::*;

    // select a pixel source by its two-bit code
    function automatic logic [PIX_W-1:0] pick_src(input logic [1:0] sel,
                                                  input logic [PIX_W-1:0] colour,
                                                  input logic [PIX_W-1:0] map_pix);
        pick_src = (sel == SRC_MAP) ? map_pix : colour;
    endfunction

    // one step of a coordinate in either direction
    function automatic logic [CRD_W-1:0] step1(input logic [CRD_W-1:0] v,
                                               input logic neg);
        step1 = neg ? v - ONE16 : v + ONE16;
    endfunction

    // reads needed for each pixel of the operation in the control word
    function automatic logic [3:0] needs(input logic [31:0] op);
        logic [3:0] n;
        n = 4'h0;
        n[NEED_DST] = 1'b1;
        n[NEED_MSK] = (op[OP_MASK +: 2] != MASK_OFF);
        n[NEED_PAT] = (op[OP_PMAP +: 4] != PAT_FIXED) && (op[OP_PMAP +: 4] != PAT_FROMSRC);
        n[NEED_SRC] = (op[OP_FGSRC +: 2] == SRC_MAP) || (op[OP_BGSRC +: 2] == SRC_MAP)
                      || (op[OP_PMAP +: 4] == PAT_FROMSRC);
        needs = n;
    endfunction

    logic [15:0] err_q, k1_q, k2_q, dim1_q, dim2_q;
    logic [15:0] dst_x_q, dst_y_q, src_x_q, src_y_q;
    logic [15:0] pat_x_q, pat_y_q, msk_x_q, msk_y_q;
    logic [7:0]  fg_mix_q, bg_mix_q, fg_col_q, bg_col_q;
    logic [31:0] op_q;
    bldm_state_t state_q;
    logic [15:0] cur_x_q, cur_y_q, werr_q, cnt_q, idx_q, prev_y_q;
    logic [3:0]  need_q;
    logic [1:0]  kind_q;
    logic        first_q, badop_q;
    logic [PIX_W-1:0] pat_pix_q, src_pix_q, dst_pix_q, msk_pix_q, last_pix_q;
    logic        start;
    logic        use_fg, draw_ok, is_write, swap, negx, negy;
    logic [7:0]  mix_code;
    logic [PIX_W-1:0] mix_src, mix_res;
    logic [31:0] rd_mux;

    // start only from idle so a running line keeps its control word
    assign start    = reg_wr && (reg_addr == OFF_PIXOP) && (state_q == S_IDLE);
    assign is_write = (op_q[OP_STEP +: 4] == STEP_LWRITE);
    assign negx     = op_q[OP_NEGX];
    assign negy     = op_q[OP_NEGY];
    assign swap     = op_q[OP_SWAP];

    // register writes from software
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            err_q <= RST16; k1_q <= RST16; k2_q <= RST16; dim1_q <= RST16;
            dim2_q <= RST16; dst_x_q <= RST16; dst_y_q <= RST16;
            src_x_q <= RST16; src_y_q <= RST16; pat_x_q <= RST16;
            pat_y_q <= RST16; msk_x_q <= RST16; msk_y_q <= RST16;
            fg_mix_q <= RST8; bg_mix_q <= RST8; fg_col_q <= RST8;
            bg_col_q <= RST8; op_q <= RST32;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                OFF_ERR:   err_q    <= reg_wdata[15:0];
                OFF_K1:    k1_q     <= reg_wdata[15:0];
                OFF_K2:    k2_q     <= reg_wdata[15:0];
                OFF_FGMIX: fg_mix_q <= reg_wdata[7:0];
                OFF_BGMIX: bg_mix_q <= reg_wdata[7:0];
                OFF_FGCOL: fg_col_q <= reg_wdata[7:0];
                OFF_BGCOL: bg_col_q <= reg_wdata[7:0];
                OFF_DIM1:  dim1_q   <= reg_wdata[15:0];
                OFF_DIM2:  dim2_q   <= reg_wdata[15:0];   // stored only
                OFF_MSKX:  msk_x_q  <= reg_wdata[15:0];
                OFF_MSKY:  msk_y_q  <= reg_wdata[15:0];
                OFF_SRCX:  src_x_q  <= reg_wdata[15:0];
                OFF_SRCY:  src_y_q  <= reg_wdata[15:0];
                OFF_PATX:  pat_x_q  <= reg_wdata[15:0];
                OFF_PATY:  pat_y_q  <= reg_wdata[15:0];
                OFF_DSTX:  dst_x_q  <= reg_wdata[15:0];
                OFF_DSTY:  dst_y_q  <= reg_wdata[15:0];
                OFF_PIXOP:
                begin
                    if (state_q == S_IDLE)
                        op_q <= reg_wdata;
                end
                default: ;
            endcase
        end
    end

    // readback mux, unmapped offsets read zero
    always_comb
    begin
        rd_mux = RST32;
        case (reg_addr)
            OFF_ERR:    rd_mux = {16'h0000, err_q};
            OFF_K1:     rd_mux = {16'h0000, k1_q};
            OFF_K2:     rd_mux = {16'h0000, k2_q};
            OFF_FGMIX:  rd_mux = {24'h000000, fg_mix_q};
            OFF_BGMIX:  rd_mux = {24'h000000, bg_mix_q};
            OFF_FGCOL:  rd_mux = {24'h000000, fg_col_q};
            OFF_BGCOL:  rd_mux = {24'h000000, bg_col_q};
            OFF_DIM1:   rd_mux = {16'h0000, dim1_q};
            OFF_DIM2:   rd_mux = {16'h0000, dim2_q};
            OFF_MSKX:   rd_mux = {16'h0000, msk_x_q};
            OFF_MSKY:   rd_mux = {16'h0000, msk_y_q};
            OFF_SRCX:   rd_mux = {16'h0000, src_x_q};
            OFF_SRCY:   rd_mux = {16'h0000, src_y_q};
            OFF_PATX:   rd_mux = {16'h0000, pat_x_q};
            OFF_PATY:   rd_mux = {16'h0000, pat_y_q};
            OFF_DSTX:   rd_mux = {16'h0000, dst_x_q};
            OFF_DSTY:   rd_mux = {16'h0000, dst_y_q};
            OFF_PIXOP:  rd_mux = op_q;
            OFF_STATUS:
            begin
                rd_mux[ST_BUSY]           = busy_q;
                rd_mux[ST_BADOP]          = badop_q;
                rd_mux[ST_PIX +: PIX_W]   = last_pix_q;
            end
            default: rd_mux = RST32;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            reg_rdata_q <= RST32;
        else
            reg_rdata_q <= reg_rd ? rd_mux : RST32;
    end

    // pixel class, mix choice and write permission
    always_comb
    begin
        if (op_q[OP_PMAP +: 4] == PAT_FIXED)
            use_fg = 1'b1;
        else if (op_q[OP_PMAP +: 4] == PAT_FROMSRC)
            use_fg = (src_pix_q != RST8);
        else
            use_fg = (pat_pix_q != RST8);
        mix_code = use_fg ? fg_mix_q : bg_mix_q;
        mix_src  = use_fg ? pick_src(op_q[OP_FGSRC +: 2], fg_col_q, src_pix_q)
                          : pick_src(op_q[OP_BGSRC +: 2], bg_col_q, src_pix_q);
        case (op_q[OP_MODE +: 2])
            MODE_ALL:    draw_ok = 1'b1;
            MODE_FIRSTN: draw_ok = !first_q;
            MODE_LASTN:  draw_ok = (cnt_q != RST16);
            MODE_BOUND:  draw_ok = first_q || (cur_y_q != prev_y_q);
            default:     draw_ok = 1'b1;
        endcase
        if (op_q[OP_MASK +: 2] != MASK_OFF)
            draw_ok = draw_ok && (msk_pix_q != RST8);
    end

    bldm_mix_unit u_mix (
        .code (mix_code),
        .src  (mix_src),
        .dst  (dst_pix_q),
        .res  (mix_res)
    );

    // sequencer and bresenham walker
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_q <= S_IDLE; cur_x_q <= RST16; cur_y_q <= RST16;
            werr_q <= RST16; cnt_q <= RST16; idx_q <= RST16;
            prev_y_q <= RST16; need_q <= 4'h0; kind_q <= 2'h0;
            first_q <= 1'b0; busy_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= S_SETUP;
                        busy_q  <= 1'b1;
                    end
                end
                S_SETUP:
                begin
                    cur_x_q <= dst_x_q;
                    cur_y_q <= dst_y_q;
                    werr_q  <= err_q;
                    cnt_q   <= dim1_q;
                    idx_q   <= RST16;
                    first_q <= 1'b1;
                    need_q  <= needs(op_q);
                    if (is_write || (op_q[OP_STEP +: 4] == STEP_LREAD))
                        state_q <= S_RD;
                    else
                    begin
                        state_q <= S_IDLE;
                        busy_q  <= 1'b0;
                    end
                end
                S_RD:
                begin
                    if (need_q[NEED_MSK])
                        kind_q <= 2'(NEED_MSK);
                    else if (need_q[NEED_PAT])
                        kind_q <= 2'(NEED_PAT);
                    else if (need_q[NEED_SRC])
                        kind_q <= 2'(NEED_SRC);
                    else
                        kind_q <= 2'(NEED_DST);
                    state_q <= S_CAP;
                end
                S_CAP:
                begin
                    need_q[kind_q] <= 1'b0;
                    if ((need_q & ~(4'h1 << kind_q)) == 4'h0)
                        state_q <= S_WR;
                    else
                        state_q <= S_RD;
                end
                S_WR:
                begin
                    if (draw_ok)
                        prev_y_q <= cur_y_q;
                    first_q <= 1'b0;
                    state_q <= S_STEP;
                end
                S_STEP:
                begin
                    if (cnt_q == RST16)
                    begin
                        state_q <= S_IDLE;
                        busy_q  <= 1'b0;
                    end
                    else
                    begin
                        cnt_q  <= cnt_q - ONE16;
                        idx_q  <= idx_q + ONE16;
                        need_q <= needs(op_q);
                        // major axis is y when swapped, x otherwise
                        if (werr_q[15])
                        begin
                            werr_q <= werr_q + k1_q;
                            if (swap)
                                cur_y_q <= step1(cur_y_q, negy);
                            else
                                cur_x_q <= step1(cur_x_q, negx);
                        end
                        else
                        begin
                            werr_q  <= werr_q + k2_q;
                            cur_x_q <= step1(cur_x_q, negx);
                            cur_y_q <= step1(cur_y_q, negy);
                        end
                        state_q <= S_RD;
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // pixel memory port
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            mem_rd_q <= 1'b0; mem_wr_q <= 1'b0; mem_map_q <= 4'h0;
            mem_x_q <= RST16; mem_y_q <= RST16; mem_wdata_q <= RST8;
        end
        else
        begin
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            if (state_q == S_RD)
            begin
                mem_rd_q <= 1'b1;
                if (need_q[NEED_MSK])
                begin
                    mem_map_q <= MAP_MASK_ID;
                    mem_x_q   <= cur_x_q - msk_x_q;
                    mem_y_q   <= cur_y_q - msk_y_q;
                end
                else if (need_q[NEED_PAT])
                begin
                    mem_map_q <= op_q[OP_PMAP +: 4];
                    mem_x_q   <= pat_x_q + idx_q;
                    mem_y_q   <= pat_y_q;
                end
                else if (need_q[NEED_SRC])
                begin
                    mem_map_q <= op_q[OP_SMAP +: 4];
                    mem_x_q   <= src_x_q + idx_q;
                    mem_y_q   <= src_y_q;
                end
                else
                begin
                    mem_map_q <= op_q[OP_DMAP +: 4];
                    mem_x_q   <= cur_x_q;
                    mem_y_q   <= cur_y_q;
                end
            end
            else if ((state_q == S_WR) && is_write && draw_ok)
            begin
                mem_wr_q    <= 1'b1;
                mem_map_q   <= op_q[OP_DMAP +: 4];
                mem_x_q     <= cur_x_q;
                mem_y_q     <= cur_y_q;
                mem_wdata_q <= mix_res;
            end
        end
    end

    // captured pixels, read result and unsupported-step flag
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pat_pix_q <= RST8; src_pix_q <= RST8; dst_pix_q <= RST8;
            msk_pix_q <= RST8; last_pix_q <= RST8; badop_q <= 1'b0;
        end
        else
        begin
            if (state_q == S_CAP)
            begin
                case (kind_q)
                    2'(NEED_MSK): msk_pix_q <= mem_rdata;
                    2'(NEED_PAT): pat_pix_q <= mem_rdata;
                    2'(NEED_SRC): src_pix_q <= mem_rdata;
                    default:      dst_pix_q <= mem_rdata;
                endcase
            end
            if ((state_q == S_WR) && !is_write)
                last_pix_q <= dst_pix_q;
            if (state_q == S_SETUP)
                badop_q <= !(is_write || (op_q[OP_STEP +: 4] == STEP_LREAD));
        end
    end
endmodule

// [bldm_line_asserts.sv]
// port checker for the line engine
// assumes binding onto bldm_line_engine, one clock
`timescale 1ns/1ps
module bldm_line_asserts (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic        busy_q,
    input wire logic        mem_rd_q,
    input wire logic        mem_wr_q,
    input wire logic [3:0]  mem_map_q,
    input wire logic [15:0] mem_x_q,
    input wire logic [15:0] mem_y_q,
    input wire logic [7:0]  mem_wdata_q
);
    logic [31:0] op_q;
    logic [15:0] sx_q;
    logic [15:0] sy_q;
    logic [7:0]  mix_q;
    logic [7:0]  col_q;
    wire st = reg_wr && !busy_q && reg_addr == 8'h7c;
    wire solid = op_q[31:28] == 4'h0 && op_q[15:12] == 4'h8 && op_q[7:6] == 2'h0;
    wire ln = op_q[24] && !op_q[27] && op_q[26] != op_q[25];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // shadow of the loaded parameters
    always_ff @(posedge clk_sys)
    begin
        if (st) op_q <= reg_wdata;
        if (reg_wr && reg_addr == 8'h78) sx_q <= reg_wdata[15:0];
        if (reg_wr && reg_addr == 8'h7a) sy_q <= reg_wdata[15:0];
        if (reg_wr && reg_addr == 8'h48) mix_q <= reg_wdata[7:0];
        if (reg_wr && reg_addr == 8'h58) col_q <= reg_wdata[7:0];
    end
    start_busy_a: assert property (st && reg_wdata[27:24] == 4'h5 |=> busy_q)
        else $error("line write did not start");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
        else $error("read data outside read slot");
    wr_busy_a: assert property (mem_wr_q |-> busy_q)
        else $error("pixel write while idle");
    wr_after_rd_a: assert property (mem_wr_q |-> $past(mem_rd_q, 2))
        else $error("write not after destination read");
    wr_map_a: assert property (mem_wr_q |-> mem_map_q == op_q[19:16])
        else $error("write to wrong map");
    read_no_wr_a: assert property (busy_q && op_q[27:24] == 4'h3 |-> !mem_wr_q)
        else $error("line read op wrote a pixel");
    first_px_a: assert property ($rose(busy_q) && solid && ln
        |-> ##2 mem_rd_q && mem_x_q == sx_q && mem_y_q == sy_q)
        else $error("first pixel not at start point");
    solid_col_a: assert property (mem_wr_q && solid && mix_q == 8'h03
        |-> mem_wdata_q == col_q)
        else $error("solid pixel not foreground colour");
    busy_end_a: assert property ($rose(busy_q) |-> ##[1:1000] !busy_q)
        else $error("operation never ended");
endmodule
bind bldm_line_engine bldm_line_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .busy_q(busy_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q),
    .mem_map_q(mem_map_q), .mem_x_q(mem_x_q), .mem_y_q(mem_y_q), .mem_wdata_q(mem_wdata_q));

// [bresenham_line_draw_mix_bench.sv]
// self-checking bench: lines drawn against a bench model of walk and mix
// assumes bldm_pkg and the checker are compiled first
`timescale 1ns/1ps
module bresenham_line_draw_mix_bench;
    import bldm_pkg::*;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        busy_q, mem_rd_q, mem_wr_q;
    logic [7:0]  reg_addr = 8'h00, mem_rdata = 8'h00, mem_wdata_q, last_px;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_q, seed = 32'h62f5d348;
    logic [3:0]  mem_map_q;
    logic [15:0] mem_x_q, mem_y_q;
    logic [31:0] expq[$];
    int          miscompares = 0, total_checks = 0, mix, fgc;
    bldm_line_engine dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .busy_q(busy_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_map_q(mem_map_q),
        .mem_x_q(mem_x_q), .mem_y_q(mem_y_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata));
    initial forever #50 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int r(int m);
        return int'(xs() % m);
    endfunction
    // bench model of the mix unit
    function automatic logic [31:0] mixf(int c, int s, int d);
        logic [7:0] v;
        for (int b = 0; b < 8; b++) v[b] = c[{~s[b], ~d[b]}];
        case (c)
            16: v = s > d ? s : d;
            17: v = s < d ? s : d;
            18: v = s + d > 255 ? 255 : s + d;
            19: v = d > s ? d - s : 0;
            20: v = s > d ? s - d : 0;
            21: v = (s + d) / 2;
            default: ;
        endcase
        return {24'h0, v};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk("rdata", reg_rdata_q, x);
    endtask
    // software normalises, loads parameters, starts and waits
    task automatic line(input int dx, input int dy, input logic [3:0] step,
                        input logic [1:0] md);
        int nx, ny, x, y, e, n, py;
        logic [2:0] oc;
        logic s;
        nx = dx < 0 ? -dx : dx;
        ny = dy < 0 ? -dy : dy;
        if (nx == 0 && ny == 0) nx = 1;
        oc = {dx < 0, dy < 0, ny >= nx};
        if (oc[0]) {nx, ny} = {ny, nx};
        e = 2 * ny - nx;
        x = 200 + r(50);
        y = 200 + r(50);
        wr(8'h20, e);
        wr(8'h24, 2 * ny);
        wr(8'h28, 2 * (ny - nx));
        wr(8'h60, nx - 1);
        wr(8'h62, xs());
        wr(8'h78, x);
        wr(8'h7a, y);
        wr(8'h48, mix);
        wr(8'h58, fgc);
        for (int i = 0; i < nx; i++)
        begin
            if (step == 4'h5 && (md == 2'h0 || (md == 2'h1 && i > 0)
                || (md == 2'h2 && i < nx - 1) || (md == 2'h3 && (i == 0 || y != py))))
            begin
                expq.push_back({x[15:0], y[15:0]});
                py = y;
            end
            s = e >= 0;
            e += s ? 2 * (ny - nx) : 2 * ny;
            if (oc[0] | s) y += oc[1] ? -1 : 1;
            if (!oc[0] | s) x += oc[2] ? -1 : 1;
        end
        wr(8'h7c, {4'h0, step, 8'h11, 8'h80, 2'h0, md, 1'b0, oc});
        @(negedge clk_sys);
        for (n = 0; n < 2000 && busy_q !== 1'b0; n++) @(posedge clk_sys);
        if (n == 2000)
        begin
            chk("timeout", 1, 0);
            report_and_stop();
        end
        chk("left", expq.size(), 0);
    endtask
    // pixel memory: fresh random data each cycle, taken while the read strobe stands
    always @(posedge clk_sys)
    begin
        if (mem_rd_q)
            last_px = mem_rdata;
        mem_rdata <= 8'(xs());
        if (mem_wr_q)
        begin
            chk("pixel", mem_wdata_q, mixf(mix, fgc, last_px));
            chk("coord", {mem_x_q, mem_y_q}, expq.pop_front());
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        mix = 3;
        fgc = 5;
        line(60, 20, 4'h5, 2'h0);
        rd(8'h24, 32'd40);
        rd(8'h10, 32'h0);
        for (int c = 0; c < 22; c++)
        begin
            mix = c;
            fgc = r(256);
            line(r(17) - 8, r(17) - 8, 4'h5, c[1:0]);
        end
        line(5, -3, 4'h3, 2'h0);
        rd(8'h80, {16'h0, last_px, 8'h00});
        line(3, 2, 4'h8, 2'h0);
        rd(8'h80, {16'h0, last_px, 8'h02});
        report_and_stop();
    end
endmodule
